// *** core/tsp_pkg.sv ***
/*
 * Constants for the three-wire serial port: register indices, field positions,
 * reset values and the master clock divider.
 * Assumes pclk is the internal E clock.
 */
`default_nettype none
package tsp_pkg;
   // ---------------------------------------------------------------
   // register map (index; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [5:0] IDX_CONTROL = 6'h10;
   localparam logic [5:0] IDX_STATUS = 6'h11;
   localparam logic [5:0] IDX_DATA = 6'h12;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTL_IRQ_EN_BIT = 7;
   localparam int unsigned CTL_PORT_EN_BIT = 6;
   localparam int unsigned CTL_MASTER_BIT = 4;
   localparam int unsigned STS_COMPLETE_BIT = 7;
   localparam int unsigned STS_COLLISION_BIT = 6;
   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MASTER_DIV = 4;
   localparam int unsigned HALF_CYCLES = MASTER_DIV / 2;
   localparam logic [1:0] HALF_LAST = 2'(HALF_CYCLES - 1);
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [4:0] LAST_HALF = 5'h0F;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic irq_en;
      logic port_en;
      logic master_select;
      logic [7:0] shreg;
      logic rx_bit;
      logic [7:0] rxbuf;
      logic [3:0] bitcnt;
      logic busy;
      logic flag;
      logic coll;
      logic seen;
      logic sck_prev;
      logic sck_o;
      logic mrun;
      logic [1:0] div;
      logic [4:0] hcnt;
      logic ser_oe;
      logic clk_oe;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tsp_state_t;
endpackage : tsp_pkg
`default_nettype wire

// *** core/tsp_serial_port.sv ***
/*
 * Three-wire serial port: one 8-bit full-duplex exchange per transfer, MSB first,
 * master or slave, with an APB register slave.
 * Assumes all pin inputs are synchronous to pclk (the E clock); pin drive is
 * resolved outside from the output enables.
 */
//
// Overview of operation
// R1 - serial clock idles high between transfers
// R2 - first falling edge starts, MSB presented
// R3 - input bit sampled on rising edge
// R4 - later falling edges shift; end after LSB
// R5 - master drives clock at E over four
// R6 - MSB first; idle output is last stage
// R7 - data write loads shifter; master starts
// R8 - byte done: copy to buffer, set flag
// R9 - slave shifts on external clock
// R10 - data pins keep roles in master mode
// R11 - enabled flag raises interrupt request
// R12 - port enable sets pin directions
// R13 - port disable releases pins, aborts transfer
// R14 - master select writable anytime; clear aborts
// R15 - flag set at exchange end, reset clears
// R16 - flag cleared by status then data access
// R17 - master writes blocked until status read
// R18 - data access mid-transfer sets collision
// R19 - collision clears like flag; may reset
// R20 - slave write loads but never starts
// R21 - overrun keeps first byte in buffer
// R22 - transmit write goes straight to shifter
// R23 - master clock four cycles, even phases
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port
   import tsp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ser_in,
   output logic ser_out,
   output logic ser_out_oe,
   input wire logic clk_in,
   output logic clk_out,
   output logic clk_oe,
   output logic xfer_irq
);
   tsp_state_t st;
   tsp_state_t next_st;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic access;
   logic setup;
   logic aligned;
   logic hit_ctl;
   logic hit_sts;
   logic hit_dat;
   logic data_acc;
   logic wr_data;
   logic stat_rd;
   logic sck_eff;
   logic fall;
   logic rise;
   logic done;
   logic abort;
   logic [7:0] rx_byte;

   assign access = psel && penable && st.pready;
   assign setup = psel && !penable;
   assign aligned = (paddr[1:0] == 2'h0);
   assign hit_ctl = aligned && (paddr[7:2] == IDX_CONTROL);
   assign hit_sts = aligned && (paddr[7:2] == IDX_STATUS);
   assign hit_dat = aligned && (paddr[7:2] == IDX_DATA);
   assign data_acc = access && hit_dat;
   assign wr_data = data_acc && pwrite;
   assign stat_rd = access && hit_sts && !pwrite;

   // slave follows the pin, master follows its own generator
   assign sck_eff = st.master_select ? st.sck_o : clk_in; // R9 R10
   assign fall = st.port_en && st.sck_prev && !sck_eff;
   assign rise = st.port_en && !st.sck_prev && sck_eff;
   assign rx_byte = {st.shreg[6:0], ser_in};
   assign done = rise && (st.bitcnt == BYTE_BITS - 4'h1);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      abort = 1'b0;
      next_st.sck_prev = sck_eff;
      next_st.pready = setup && !st.pready;
      next_st.pslverr = setup && !(hit_ctl || hit_sts || hit_dat);
      if (setup) begin
         next_st.prdata = 32'h0000_0000;
         if (hit_ctl) begin
            next_st.prdata[CTL_IRQ_EN_BIT] = st.irq_en;
            next_st.prdata[CTL_PORT_EN_BIT] = st.port_en;
            next_st.prdata[CTL_MASTER_BIT] = st.master_select;
         end else if (hit_sts) begin
            next_st.prdata[STS_COMPLETE_BIT] = st.flag;
            next_st.prdata[STS_COLLISION_BIT] = st.coll;
         end else if (hit_dat) begin
            next_st.prdata[7:0] = st.rxbuf; // R8
         end
      end
      if (access && pwrite && hit_ctl) begin
         next_st.irq_en = pwdata[CTL_IRQ_EN_BIT];
         next_st.port_en = pwdata[CTL_PORT_EN_BIT]; // R12
         next_st.master_select = pwdata[CTL_MASTER_BIT]; // R14
         abort = (st.port_en && !pwdata[CTL_PORT_EN_BIT]) ||
                 (st.master_select && !pwdata[CTL_MASTER_BIT]); // R13 R14
      end

      // clear sequence: status read with flag set arms, data access clears
      if (stat_rd && st.flag) begin
         next_st.seen = 1'b1;
      end
      if (data_acc && st.seen) begin
         next_st.flag = 1'b0; // R16
         next_st.coll = 1'b0; // R19
         next_st.seen = 1'b0;
      end

      // transmit load; no buffer, the byte goes straight to the shifter
      if (wr_data && !(st.master_select && st.flag && !st.seen)) begin // R17
         next_st.shreg = pwdata[7:0]; // R7 R22
         if (st.master_select && st.port_en && !st.busy && !st.mrun) begin // R20
            next_st.mrun = 1'b1; // R7
            next_st.div = 2'h0;
            next_st.hcnt = 5'h00;
            next_st.sck_o = 1'b1;
         end
      end

      // master clock: toggle every half period, 16 halves per byte
      if (st.mrun) begin
         next_st.div = st.div + 2'h1;
         if (st.div == HALF_LAST) begin
            next_st.div = 2'h0;
            next_st.sck_o = !st.sck_o; // R5 R23
            next_st.hcnt = st.hcnt + 5'h01;
            if (st.hcnt == LAST_HALF) begin
               next_st.mrun = 1'b0; // R1
            end
         end
      end

      // shifting
      if (fall) begin
         if (!st.busy) begin
            next_st.busy = 1'b1; // R2
         end else begin
            next_st.shreg = {st.shreg[6:0], st.rx_bit}; // R4 R6
         end
      end
      if (rise && st.busy) begin
         next_st.rx_bit = ser_in; // R3
         next_st.bitcnt = st.bitcnt + 4'h1;
         if (done) begin
            next_st.shreg = rx_byte;
            next_st.bitcnt = 4'h0;
            next_st.busy = 1'b0; // R4
            next_st.flag = 1'b1; // R15
            if (!st.flag) begin
               next_st.rxbuf = rx_byte; // R8 R21
            end
         end
      end

      // collision set wins over the clear in the same cycle
      if (data_acc && st.busy) begin
         next_st.coll = 1'b1; // R18 R19
      end

      // an abort drops the bit count but keeps flags and buffer
      if (abort) begin
         next_st.busy = 1'b0; // R13
         next_st.bitcnt = 4'h0;
         next_st.mrun = 1'b0;
         next_st.sck_o = 1'b1; // R1
      end
      next_st.ser_oe = next_st.port_en; // R10 R12
      next_st.clk_oe = next_st.port_en && next_st.master_select; // R5 R12
      next_st.irq = next_st.irq_en && next_st.flag; // R11
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.irq_en <= RST_CONTROL[CTL_IRQ_EN_BIT];
         st.port_en <= RST_CONTROL[CTL_PORT_EN_BIT];
         st.master_select <= RST_CONTROL[CTL_MASTER_BIT];
         st.shreg <= RST_DATA;
         st.rxbuf <= RST_DATA;
         st.sck_prev <= 1'b1;
         st.sck_o <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign ser_out = st.shreg[7]; // R6
   assign ser_out_oe = st.ser_oe;
   assign clk_out = st.sck_o;
   assign clk_oe = st.clk_oe;
   assign xfer_irq = st.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_arm;
      stat_rd && st.flag;
   endsequence

   sequence s_clear;
      data_acc && !done && !st.busy;
   endsequence

   sequence s_low_half;
      $fell(clk_out) && st.mrun;
   endsequence

   idle_clock_high_a: assert property (!st.mrun |-> clk_out) // R1
      else $error("master clock not high while idle");
   half_period_a: assert property (s_low_half |=> (!clk_out ##1 (clk_out || !st.mrun))) // R23
      else $error("master clock low phase not two cycles");
   high_half_a: assert property ($rose(clk_out) && st.mrun |=> clk_out) // R5
      else $error("master clock high phase too short");
   buffer_copy_a: assert property ($rose(st.flag) |-> st.rxbuf == st.shreg) // R8
      else $error("receive buffer not copied with flag");
   overrun_keep_a: assert property (st.flag && $past(st.flag) |-> $stable(st.rxbuf)) // R21
      else $error("receive buffer overwritten during overrun");
   irq_gate_a: assert property (xfer_irq == (st.flag && st.irq_en)) // R11
      else $error("interrupt request does not follow flag and enable");
   flag_clear_a: assert property (s_arm ##1 (!data_acc)[*2] ##1 s_clear |=> !st.flag) // R16
      else $error("flag not cleared by status then data access");
   flag_hold_a: assert property ($fell(st.flag) |-> $past(data_acc && st.seen)) // R16
      else $error("flag cleared without clearing sequence");
   write_block_a: assert property (wr_data && st.master_select && st.flag && !st.seen && !st.busy
      |=> $stable(st.shreg) && !st.mrun) // R17
      else $error("blocked master write took effect");
   collision_set_a: assert property (data_acc && st.busy |=> st.coll) // R18
      else $error("collision not flagged");
   slave_nostart_a: assert property (wr_data && !st.master_select |=> !st.mrun) // R20
      else $error("slave write started the clock");
   abort_clear_a: assert property (!st.port_en |-> !st.busy && st.bitcnt == 4'h0) // R13
      else $error("transfer survives port disable");
   master_start_a: assert property (wr_data && st.master_select && st.port_en && !st.flag && !st.busy
      && !st.mrun |=> st.mrun ##2 !clk_out) // R7
      else $error("master write did not start the clock");

   // ---------------------------------------------------------------
   // register access checks
   // ---------------------------------------------------------------
   sequence s_ctl_write;
      access && pwrite && hit_ctl;
   endsequence

   data_read_a: assert property ( // R8
      setup && hit_dat && !pwrite
      |=> prdata[7:0] == $past(st.rxbuf))
      else $error("data read did not return the receive buffer");
   status_read_a: assert property ( // R15
      setup && hit_sts
      |=> prdata[STS_COMPLETE_BIT] == $past(st.flag) && prdata[STS_COLLISION_BIT] == $past(st.coll))
      else $error("status read did not return the flags");
   control_read_a: assert property ( // R14
      setup && hit_ctl
      |=> prdata[CTL_MASTER_BIT] == $past(st.master_select) && prdata[CTL_IRQ_EN_BIT] == $past(st.irq_en))
      else $error("control read did not return the enables");
   master_write_a: assert property ( // R14
      s_ctl_write
      |=> st.master_select == $past(pwdata[CTL_MASTER_BIT]))
      else $error("master select write lost");
   port_write_a: assert property ( // R12
      s_ctl_write
      |=> st.port_en == $past(pwdata[CTL_PORT_EN_BIT]) && ser_out_oe == st.port_en)
      else $error("port enable write lost");
   irq_en_write_a: assert property ( // R11
      s_ctl_write
      |=> st.irq_en == $past(pwdata[CTL_IRQ_EN_BIT]))
      else $error("interrupt enable write lost");
   master_abort_a: assert property ( // R14
      s_ctl_write ##0 (st.master_select && !pwdata[CTL_MASTER_BIT])
      |=> !st.mrun && !st.busy && clk_out)
      else $error("clearing master select did not abort");
   port_abort_a: assert property ( // R13
      s_ctl_write ##0 (st.port_en && !pwdata[CTL_PORT_EN_BIT])
      |=> !st.busy && st.bitcnt == 4'h0 && !ser_out_oe)
      else $error("clearing port enable did not abort");

   // ---------------------------------------------------------------
   // shift checks
   // ---------------------------------------------------------------
   // an abort in the same cycle outranks the edge, so it is left out here
   sequence s_edge_fall;
      fall && !abort;
   endsequence

   first_fall_a: assert property ( // R2
      s_edge_fall
      |=> st.busy)
      else $error("falling edge did not mark the transfer busy");
   slave_fall_a: assert property ( // R9
      s_edge_fall ##0 (!st.master_select && !clk_in)
      |=> st.busy && !st.mrun)
      else $error("slave did not follow the external clock");
   shift_fall_a: assert property ( // R4
      fall && st.busy
      |=> st.shreg == $past({st.shreg[6:0], st.rx_bit}))
      else $error("falling edge did not shift the register");
   rise_sample_a: assert property ( // R3
      rise && st.busy
      |=> st.rx_bit == $past(ser_in))
      else $error("rising edge did not sample the input");
   byte_done_a: assert property ( // R15
      done && st.busy
      |=> st.flag && !st.busy && st.bitcnt == 4'h0)
      else $error("eighth rising edge did not end the transfer");
   count_bound_a: assert property ( // R4
      st.bitcnt <= 4'h7)
      else $error("bit count ran past one byte");
   buffer_write_a: assert property ( // R21
      $changed(st.rxbuf)
      |-> $past(done && !st.flag))
      else $error("receive buffer written outside a clean completion");

   // ---------------------------------------------------------------
   // flag and pin checks
   // ---------------------------------------------------------------
   coll_cause_a: assert property ( // R18
      $rose(st.coll)
      |-> $past(data_acc && st.busy))
      else $error("collision flag set without a mid-transfer access");
   coll_clear_a: assert property ( // R19
      $fell(st.coll)
      |-> $past(data_acc && st.seen))
      else $error("collision flag cleared without clearing sequence");
   slave_clock_a: assert property ( // R1
      !st.mrun && !st.master_select
      |-> clk_out)
      else $error("generated clock not high in slave mode");
   stream_order_a: assert property ( // R6
      $rose(st.flag) && !$past(st.flag)
      |-> ser_out == st.rxbuf[7])
      else $error("output does not show the first received bit");
endmodule : tsp_serial_port
`default_nettype wire

// *** dv/tsp_far_end.sv ***
/*
 * Far-end peer of the three-wire serial port: a slave that answers the
 * port's clock, or a master that makes the clock itself on request.
 * Assumes pins synchronous to pclk; the data line has no pull resistor.
 */
`timescale 1ns/1ps
`default_nettype none
module tsp_far_end (
   input wire logic pclk,
   input wire logic dut_clk,
   input wire logic dut_sdo,
   input wire logic [7:0] tx_byte,
   output logic far_clk,
   output logic far_sdo,
   output logic [7:0] rx_byte
);
   logic is_master = 1'b0;
   logic prev = 1'b1;
   logic [3:0] idle = 4'h0;
   logic [7:0] sh = 8'h00;
   wire logic sck = is_master ? far_clk : dut_clk;
   initial far_clk = 1'b1;
   initial far_sdo = 1'b0;
   initial rx_byte = 8'h00;
   // -------------------------------------------------
   // shifter: long high time means the next fall starts a byte
   // -------------------------------------------------
   always @(posedge pclk) begin
      prev <= sck;
      if (!sck) begin
         idle <= 4'h0;
      end else if (idle != 4'hF) begin
         idle <= idle + 4'h1;
      end
      if (prev && !sck) begin
         far_sdo <= (idle > 4'h5) ? tx_byte[7] : sh[7];
         sh <= (idle > 4'h5) ? {tx_byte[6:0], 1'b0} : {sh[6:0], 1'b0};
      end else if (!prev && sck) begin
         rx_byte <= {rx_byte[6:0], dut_sdo};
      end else if (idle > 4'h5) begin
         // released line: no stale level that could pass for data
         far_sdo <= ~far_sdo;
      end
   end
   task automatic run_master(input int half);
      is_master = 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         far_clk <= i[0];
         repeat (half - 1) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      is_master = 1'b0;
   endtask : run_master
endmodule : tsp_far_end
`default_nettype wire

// *** dv/three_wire_serial_port_test.sv ***
/*
 * Self-checking bench for the three-wire serial port over APB.
 * Assumes the far-end model is the only other party on the serial pins.
 */
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_port_test
   import tsp_pkg::*;
;
   localparam logic [7:0] A_CTL = {IDX_CONTROL, 2'b00};
   localparam logic [7:0] A_STS = {IDX_STATUS, 2'b00};
   localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
   logic [7:0] paddr = 8'h00, tx_byte = 8'h3C, rx_byte;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, ser_out, ser_out_oe, clk_out, clk_oe, xfer_irq, far_clk, far_sdo;
   int miscompares = 0, n_compared = 0;
   tsp_serial_port tsp_serial_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ser_in(far_sdo), .ser_out(ser_out),
      .ser_out_oe(ser_out_oe), .clk_in(far_clk), .clk_out(clk_out), .clk_oe(clk_oe),
      .xfer_irq(xfer_irq));
   tsp_far_end tsp_far_end_i (.pclk(pclk), .dut_clk(clk_out), .dut_sdo(ser_out),
      .tx_byte(tx_byte), .far_clk(far_clk), .far_sdo(far_sdo), .rx_byte(rx_byte));
   initial forever #10 pclk = ~pclk;
   // -------------------------------------------------
   // access and compare tasks
   // -------------------------------------------------
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // look mid-cycle, where the registered answer has settled
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (n == 20) begin
         miscompares++;
         $display("[FAIL] %0t: no ready", $time);
      end
      q = prdata;
      last_err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   // bounded wait for the interrupt request, or for the first clock fall
   task automatic wait_for(input logic want_irq);
      for (int n = 0; n < 200; n++) begin
         @(negedge pclk);
         if (want_irq ? (xfer_irq === 1'b1) : (clk_out === 1'b0)) return;
      end
      miscompares++;
      $display("[FAIL] %0t: wait timed out", $time);
   endtask : wait_for
   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk({clk_out, clk_oe, ser_out_oe, xfer_irq}, 32'h8);
      rd(A_CTL, 32'h0);
      rd(A_STS, 32'h0);
      acc(1'b0, 8'h4C, 32'h0);
      chk(last_err, 32'h1);
      acc(1'b1, A_CTL, 32'hD0);
      acc(1'b1, A_DAT, 32'hA5);
      wait_for(1'b1);
      chk({clk_oe, ser_out_oe}, 32'h3);
      chk(rx_byte, 32'hA5);
      chk(ser_out, 32'h0);
      acc(1'b1, A_DAT, 32'hFF);
      repeat (40) @(posedge pclk);
      chk(rx_byte, 32'hA5);
      rd(A_STS, 32'h80);
      rd(A_DAT, 32'h3C);
      rd(A_STS, 32'h0);
      chk(xfer_irq, 32'h0);
      tx_byte <= 8'h81;
      acc(1'b1, A_DAT, 32'h5A);
      wait_for(1'b0);
      acc(1'b0, A_DAT, 32'h0);
      wait_for(1'b1);
      rd(A_STS, 32'hC0);
      rd(A_DAT, 32'h81);
      rd(A_STS, 32'h0);
      acc(1'b1, A_DAT, 32'h33);
      wait_for(1'b0);
      acc(1'b1, A_CTL, 32'h0);
      repeat (40) @(posedge pclk);
      chk({clk_out, clk_oe, ser_out_oe}, 32'h4);
      rd(A_STS, 32'h0);
      tx_byte <= 8'h6E;
      acc(1'b1, A_CTL, 32'hD0);
      acc(1'b1, A_DAT, 32'hC7);
      wait_for(1'b1);
      chk(rx_byte, 32'hC7);
      rd(A_STS, 32'h80);
      rd(A_DAT, 32'h6E);
      acc(1'b1, A_CTL, 32'h40);
      acc(1'b1, A_DAT, 32'hC3);
      repeat (20) @(posedge pclk);
      chk({clk_out, clk_oe, ser_out_oe}, 32'h5);
      rd(A_STS, 32'h0);
      tx_byte <= 8'h96;
      tsp_far_end_i.run_master(4);
      chk(rx_byte, 32'hC3);
      tx_byte <= 8'h0F;
      tsp_far_end_i.run_master(2);
      chk(rx_byte, 32'h96);
      chk(xfer_irq, 32'h0);
      rd(A_STS, 32'h80);
      rd(A_DAT, 32'h96);
      rd(A_STS, 32'h0);
      results();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      results();
   end
endmodule : three_wire_serial_port_test
`default_nettype wire
